// >>> design/abie_pkg.sv
// Constants and types shared by the add, AND and bit instruction executor
package abie_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BADDR_W = 6;
  localparam int unsigned BIDX_W = 3;

  // Opcode fields, bits 13:8 for byte and literal groups, 13:9 for bit group
  localparam logic [5:0] OPC_ADD_LIT = 6'h1C;
  localparam logic [5:0] OPC_AND_LIT = 6'h1B;
  localparam logic [5:0] OPC_ADD_REG = 6'h07;
  localparam logic [5:0] OPC_AND_REG = 6'h05;
  localparam logic [4:0] OPC_BIT_CLR = 5'h08;
  localparam logic [4:0] OPC_BIT_SET = 5'h09;
  localparam logic [4:0] OPC_BIT_TST = 5'h0A;

  // Field positions inside the instruction word
  localparam int unsigned OP6_LSB = 8;
  localparam int unsigned OP5_LSB = 9;
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned BIDX_LSB = 6;
  localparam int unsigned LIT_LSB = 0;
  localparam int unsigned FADDR_LSB = 0;

  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_REG = 1'h1;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic FLAG_RST = 1'h0;

  // Cycles taken by a bit test whose skip is taken
  localparam int unsigned SKIP_CYCLES = 2;

  typedef enum logic [2:0] {
    ABIE_K_NONE,
    ABIE_K_ADD_LIT,
    ABIE_K_ADD_REG,
    ABIE_K_AND_LIT,
    ABIE_K_AND_REG,
    ABIE_K_BIT_CLR,
    ABIE_K_BIT_SET,
    ABIE_K_BIT_TST
  } abie_kind_t;
endpackage : abie_pkg

// >>> design/abie_alu.sv
// Eight-bit add and AND unit with carry, half carry and zero outputs
module abie_alu #(
  parameter int unsigned W = 8
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic op_and,
  output logic [W-1:0] result,
  output logic carry,
  output logic half_carry,
  output logic zero
);
  logic [W:0] sum;
  logic [4:0] low_sum;

  assign sum = {1'b0, a} + {1'b0, b};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign result = op_and ? (a & b) : sum[W-1:0];
  assign carry = sum[W];
  assign half_carry = low_sum[4];
  assign zero = (result == '0);
endmodule : abie_alu

// >>> design/abie_exec.sv
// Executor for literal and register add and AND and the bit clear, set and test-skip
module abie_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0] rf_rdata,
  output logic [6:0] rf_raddr,
  output logic rf_we_q,
  output logic [6:0] rf_waddr_q,
  output logic [7:0] rf_wdata_q,
  output logic [7:0] acc_q,
  output logic carry_q,
  output logic half_carry_flag_q,
  output logic zero_q,
  output logic skip_pending_q,
  output logic instr_squash,
  output logic instr_unknown
);
  abie_pkg::abie_kind_t kind;
  logic exec;
  logic dest;
  logic [2:0] bidx;
  logic [7:0] lit;
  logic [7:0] opnd;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_hc;
  logic alu_z;
  logic [7:0] bit_mask;
  logic is_lit;
  logic is_bit;

  assign dest = instr[abie_pkg::DEST_POS];
  assign bidx = instr[abie_pkg::BIDX_LSB +: abie_pkg::BIDX_W];
  assign lit = instr[abie_pkg::LIT_LSB +: abie_pkg::DATA_W];

  always_comb begin
    kind = abie_pkg::ABIE_K_NONE;
    case (instr[abie_pkg::OP6_LSB +: 6])
      abie_pkg::OPC_ADD_LIT: kind = abie_pkg::ABIE_K_ADD_LIT;
      abie_pkg::OPC_AND_LIT: kind = abie_pkg::ABIE_K_AND_LIT;
      abie_pkg::OPC_ADD_REG: kind = abie_pkg::ABIE_K_ADD_REG;
      abie_pkg::OPC_AND_REG: kind = abie_pkg::ABIE_K_AND_REG;
      default: begin
        // Bit group opcode is five bits wide, index sits just below it
        case (instr[abie_pkg::OP5_LSB +: 5])
          abie_pkg::OPC_BIT_CLR: kind = abie_pkg::ABIE_K_BIT_CLR;
          abie_pkg::OPC_BIT_SET: kind = abie_pkg::ABIE_K_BIT_SET;
          abie_pkg::OPC_BIT_TST: kind = abie_pkg::ABIE_K_BIT_TST;
          default: kind = abie_pkg::ABIE_K_NONE;
        endcase
      end
    endcase
  end

  assign is_lit = (kind == abie_pkg::ABIE_K_ADD_LIT) || (kind == abie_pkg::ABIE_K_AND_LIT);
  assign is_bit = (kind == abie_pkg::ABIE_K_BIT_CLR) || (kind == abie_pkg::ABIE_K_BIT_SET) ||
                  (kind == abie_pkg::ABIE_K_BIT_TST);

  assign instr_squash = instr_valid && skip_pending_q;
  assign exec = instr_valid && !skip_pending_q;
  // Other opcodes belong to other units; flagged so the core can route them
  assign instr_unknown = exec && (kind == abie_pkg::ABIE_K_NONE);

  assign rf_raddr = is_bit ? {1'b0, instr[abie_pkg::FADDR_LSB +: abie_pkg::BADDR_W]} :
                             instr[abie_pkg::FADDR_LSB +: abie_pkg::FADDR_W];

  // Forward the write still in flight so back-to-back use sees fresh data
  assign opnd = (rf_we_q && (rf_waddr_q == rf_raddr)) ? rf_wdata_q : rf_rdata;
  assign alu_b = is_lit ? lit : opnd;
  assign bit_mask = 8'h01 << bidx;

  abie_alu #(
    .W(abie_pkg::DATA_W)
  ) u_alu (
    .a(acc_q),
    .b(alu_b),
    .op_and((kind == abie_pkg::ABIE_K_AND_LIT) || (kind == abie_pkg::ABIE_K_AND_REG)),
    .result(alu_res),
    .carry(alu_c),
    .half_carry(alu_hc),
    .zero(alu_z)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= abie_pkg::ACC_RST;
    end else if (exec) begin
      case (kind)
        abie_pkg::ABIE_K_ADD_LIT, abie_pkg::ABIE_K_AND_LIT: acc_q <= alu_res;
        abie_pkg::ABIE_K_ADD_REG, abie_pkg::ABIE_K_AND_REG: begin
          if (dest == abie_pkg::DEST_ACC) begin
            acc_q <= alu_res;
          end
        end
        default: acc_q <= acc_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      carry_q <= abie_pkg::FLAG_RST;
      half_carry_flag_q <= abie_pkg::FLAG_RST;
      zero_q <= abie_pkg::FLAG_RST;
    end else if (exec) begin
      case (kind)
        abie_pkg::ABIE_K_ADD_LIT, abie_pkg::ABIE_K_ADD_REG: begin
          carry_q <= alu_c;
          half_carry_flag_q <= alu_hc;
          zero_q <= alu_z;
        end
        abie_pkg::ABIE_K_AND_LIT, abie_pkg::ABIE_K_AND_REG: zero_q <= alu_z;
        default: zero_q <= zero_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rf_we_q <= 1'b0;
      rf_waddr_q <= '0;
      rf_wdata_q <= '0;
    end else begin
      rf_we_q <= 1'b0;
      if (exec) begin
        case (kind)
          abie_pkg::ABIE_K_ADD_REG, abie_pkg::ABIE_K_AND_REG: begin
            rf_we_q <= (dest == abie_pkg::DEST_REG);
            rf_waddr_q <= rf_raddr;
            rf_wdata_q <= alu_res;
          end
          abie_pkg::ABIE_K_BIT_CLR: begin
            rf_we_q <= 1'b1;
            rf_waddr_q <= rf_raddr;
            rf_wdata_q <= opnd & ~bit_mask;
          end
          abie_pkg::ABIE_K_BIT_SET: begin
            rf_we_q <= 1'b1;
            rf_waddr_q <= rf_raddr;
            rf_wdata_q <= opnd | bit_mask;
          end
          default: rf_we_q <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      skip_pending_q <= 1'b0;
    end else if (exec && (kind == abie_pkg::ABIE_K_BIT_TST)) begin
      skip_pending_q <= !opnd[bidx];
    end else if (instr_squash) begin
      skip_pending_q <= 1'b0;
    end
  end

  // Checks
  logic [8:0] chk_sum9;
  logic [4:0] chk_sum5;
  assign chk_sum9 = {1'b0, acc_q} + {1'b0, alu_b};
  assign chk_sum5 = {1'b0, acc_q[3:0]} + {1'b0, alu_b[3:0]};

  property p_add_lit;
    @(posedge clk) disable iff (rst)
    exec && kind == abie_pkg::ABIE_K_ADD_LIT |=> acc_q == $past(chk_sum9[7:0]) &&
      zero_q == (acc_q == 8'h00);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("literal add result wrong");

  property p_add_carry;
    @(posedge clk) disable iff (rst)
    exec && (kind == abie_pkg::ABIE_K_ADD_LIT || kind == abie_pkg::ABIE_K_ADD_REG) |=>
      carry_q == $past(chk_sum9[8]) && half_carry_flag_q == $past(chk_sum5[4]);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry flags wrong");

  property p_add_reg_dest;
    @(posedge clk) disable iff (rst)
    exec && kind == abie_pkg::ABIE_K_ADD_REG && dest == abie_pkg::DEST_REG |=>
      rf_we_q && rf_waddr_q == $past(instr[6:0]) && $stable(acc_q) &&
      rf_wdata_q == $past(chk_sum9[7:0]);
  endproperty
  a_add_reg_dest: assert property (p_add_reg_dest) else $error("add to register wrong");

  property p_and_lit;
    @(posedge clk) disable iff (rst)
    exec && kind == abie_pkg::ABIE_K_AND_LIT |=> acc_q == ($past(acc_q) & $past(lit)) &&
      $stable(carry_q) && $stable(half_carry_flag_q);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("literal AND wrong");

  property p_and_reg;
    @(posedge clk) disable iff (rst)
    exec && kind == abie_pkg::ABIE_K_AND_REG && dest == abie_pkg::DEST_ACC |=>
      acc_q == ($past(acc_q) & $past(opnd)) && !rf_we_q && $stable(carry_q);
  endproperty
  a_and_reg: assert property (p_and_reg) else $error("register AND wrong");

  property p_bit_clr;
    @(posedge clk) disable iff (rst)
    exec && kind == abie_pkg::ABIE_K_BIT_CLR |=> rf_we_q &&
      rf_wdata_q == ($past(opnd) & ~$past(bit_mask)) && $stable({carry_q, zero_q});
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

  property p_bit_set;
    @(posedge clk) disable iff (rst)
    exec && kind == abie_pkg::ABIE_K_BIT_SET |=> rf_we_q &&
      rf_wdata_q == ($past(opnd) | $past(bit_mask)) && $stable(half_carry_flag_q);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_bit_tst;
    @(posedge clk) disable iff (rst)
    exec && kind == abie_pkg::ABIE_K_BIT_TST |=> skip_pending_q == !$past(opnd[bidx]) &&
      !rf_we_q && $stable({carry_q, half_carry_flag_q, zero_q});
  endproperty
  a_bit_tst: assert property (p_bit_tst) else $error("bit test skip wrong");

  property p_squash;
    @(posedge clk) disable iff (rst)
    instr_squash |=> $stable(acc_q) && !rf_we_q && !skip_pending_q && $stable(zero_q);
  endproperty
  a_squash: assert property (p_squash) else $error("skipped word took effect");

  property p_bit_addr;
    @(posedge clk) disable iff (rst)
    exec && is_bit |-> rf_raddr[6] == 1'b0 ##1 (!rf_we_q || rf_waddr_q[6] == 1'b0);
  endproperty
  a_bit_addr: assert property (p_bit_addr) else $error("bit address out of range");
endmodule : abie_exec

// >>> dv/tb_abie_exec.sv
// Self-checking testbench for the add, AND and bit instruction executor
module tb_abie_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic instr_valid = 1'h0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] rf_rdata = 8'h00;
  logic [6:0] rf_raddr;
  logic rf_we_q;
  logic [6:0] rf_waddr_q;
  logic [7:0] rf_wdata_q;
  logic [7:0] acc_q;
  logic carry_q;
  logic half_carry_flag_q;
  logic zero_q;
  logic skip_pending_q;
  logic instr_squash;
  logic instr_unknown;
  int fails = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  abie_exec abie_exec_i (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .rf_rdata(rf_rdata), .rf_raddr(rf_raddr), .rf_we_q(rf_we_q), .rf_waddr_q(rf_waddr_q),
    .rf_wdata_q(rf_wdata_q), .acc_q(acc_q), .carry_q(carry_q),
    .half_carry_flag_q(half_carry_flag_q), .zero_q(zero_q), .skip_pending_q(skip_pending_q),
    .instr_squash(instr_squash), .instr_unknown(instr_unknown));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk

  // Present one word for one edge; valid stays up so words can run back to back
  task automatic issue(input logic [13:0] w, input logic [7:0] rd, input logic [6:0] ra,
      input logic unk, input logic sq);
    instr = w;
    instr_valid = 1'h1;
    rf_rdata = rd;
    #1;
    chk(instr_unknown, unk);
    chk(instr_squash, sq);
    if (!unk && !sq) chk(rf_raddr, ra);
    @(posedge clk);
    #1;
  endtask : issue

  task automatic idle();
    instr_valid = 1'h0;
    @(posedge clk);
    #1;
  endtask : idle

  // Registered results; flags packed as carry, half carry, zero
  task automatic post(input logic [7:0] a, input logic [2:0] f, input logic we,
      input logic [6:0] wa, input logic [7:0] wd);
    chk(acc_q, a);
    chk({carry_q, half_carry_flag_q, zero_q}, f);
    chk(rf_we_q, we);
    if (we) begin
      chk(rf_waddr_q, wa);
      chk(rf_wdata_q, wd);
    end
  endtask : post

  task automatic t_add_lit();
    logic [7:0] ks [4] = '{8'h15, 8'hEB, 8'h0F, 8'h01};
    logic [7:0] as [4] = '{8'h15, 8'h00, 8'h0F, 8'h10};
    logic [2:0] fs [4] = '{3'b000, 3'b111, 3'b000, 3'b010};
    for (int i = 0; i < 4; i++) begin
      issue({abie_pkg::OPC_ADD_LIT, ks[i]}, 8'h00, ks[i][6:0], 1'h0, 1'h0);
      post(as[i], fs[i], 1'h0, 7'h00, 8'h00);
    end
    idle();
    $display("add literal test done");
  endtask : t_add_lit

  task automatic t_add_reg();
    issue({abie_pkg::OPC_ADD_REG, 1'b0, 7'h7F}, 8'hF5, 7'h7F, 1'h0, 1'h0);
    post(8'h05, 3'b100, 1'h0, 7'h00, 8'h00);
    issue({abie_pkg::OPC_ADD_REG, 1'b1, 7'h2A}, 8'hFB, 7'h2A, 1'h0, 1'h0);
    post(8'h05, 3'b111, 1'h1, 7'h2A, 8'h00);
    idle();
    $display("add register test done");
  endtask : t_add_reg

  task automatic t_and();
    issue({abie_pkg::OPC_AND_LIT, 8'h5F}, 8'h00, 7'h5F, 1'h0, 1'h0);
    post(8'h05, 3'b110, 1'h0, 7'h00, 8'h00);
    issue({abie_pkg::OPC_AND_REG, 1'b1, 7'h11}, 8'hC7, 7'h11, 1'h0, 1'h0);
    post(8'h05, 3'b110, 1'h1, 7'h11, 8'h05);
    issue({abie_pkg::OPC_AND_REG, 1'b0, 7'h12}, 8'hF0, 7'h12, 1'h0, 1'h0);
    post(8'h00, 3'b111, 1'h0, 7'h00, 8'h00);
    idle();
    $display("and test done");
  endtask : t_and

  task automatic t_bits();
    issue({5'b01000, 3'd7, 6'h3F}, 8'hC7, 7'h3F, 1'h0, 1'h0);
    post(8'h00, 3'b111, 1'h1, 7'h3F, 8'h47);
    issue({5'b01001, 3'd7, 6'h01}, 8'h0A, 7'h01, 1'h0, 1'h0);
    post(8'h00, 3'b111, 1'h1, 7'h01, 8'h8A);
    issue({5'b01001, 3'd0, 6'h00}, 8'hFE, 7'h00, 1'h0, 1'h0);
    post(8'h00, 3'b111, 1'h1, 7'h00, 8'hFF);
    // Write in flight must be forwarded, so the stale read data is ignored
    issue({5'b01000, 3'd0, 6'h00}, 8'h00, 7'h00, 1'h0, 1'h0);
    post(8'h00, 3'b111, 1'h1, 7'h00, 8'hFE);
    idle();
    $display("bit clear and set test done");
  endtask : t_bits

  task automatic t_skip();
    // bit high runs the next word
    issue({5'b01010, 3'd3, 6'h05}, 8'h08, 7'h05, 1'h0, 1'h0);
    chk(skip_pending_q, 1'h0);
    post(8'h00, 3'b111, 1'h0, 7'h00, 8'h00);
    issue({abie_pkg::OPC_ADD_LIT, 8'h01}, 8'h00, 7'h01, 1'h0, 1'h0);
    post(8'h01, 3'b000, 1'h0, 7'h00, 8'h00);
    // bit low squashes the next valid word, even after a gap
    issue({5'b01010, 3'd3, 6'h05}, 8'hF7, 7'h05, 1'h0, 1'h0);
    chk(skip_pending_q, 1'h1);
    idle();
    chk(skip_pending_q, 1'h1);
    issue({abie_pkg::OPC_ADD_LIT, 8'h40}, 8'h00, 7'h40, 1'h0, 1'h1);
    chk(skip_pending_q, 1'h0);
    post(8'h01, 3'b000, 1'h0, 7'h00, 8'h00);
    issue({abie_pkg::OPC_ADD_LIT, 8'h40}, 8'h00, 7'h40, 1'h0, 1'h0);
    post(8'h41, 3'b000, 1'h0, 7'h00, 8'h00);
    idle();
    $display("bit test skip test done");
  endtask : t_skip

  task automatic t_unknown();
    // words outside the group leave state alone
    issue(14'h1D00, 8'h00, 7'h00, 1'h1, 1'h0);
    issue({5'b01011, 3'd0, 6'h00}, 8'hFF, 7'h00, 1'h1, 1'h0);
    post(8'h41, 3'b000, 1'h0, 7'h00, 8'h00);
    chk(skip_pending_q, 1'h0);
    idle();
    $display("unknown word test done");
  endtask : t_unknown

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'h0;
    post(8'h00, 3'b000, 1'h0, 7'h00, 8'h00);
    chk(skip_pending_q, 1'h0);
    @(posedge clk);
    #1;
    t_add_lit();
    t_add_reg();
    t_and();
    t_bits();
    t_skip();
    t_unknown();
    close_out();
  end

  // The tests need well under a hundred cycles; this only cuts a hang short
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule : tb_abie_exec
